// ==== logic/legacy_kbd_regs.vh ====
`ifndef LEGACY_KBD_REGS_VH
`define LEGACY_KBD_REGS_VH
// Configuration offset of the legacy support register (low byte, 16 bits wide)
`define LEGACY_KBD_SUPPORT_CTRL_OFFSET 8'hC0
`define LEGACY_KBD_SUPPORT_CTRL_RESET 16'h2000
// Field positions
`define BIT_PASSTHRU_ENDED_STATUS 15
`define BIT_USB_IRQ_ROUTE_ENABLE 13
`define BIT_USB_IRQ_ACTIVE_STATUS 12
`define BIT_CMD_PORT_WRITE_STATUS 11
`define BIT_CMD_PORT_READ_STATUS 10
`define BIT_DATA_PORT_WRITE_STATUS 9
`define BIT_DATA_PORT_READ_STATUS 8
`define BIT_PASSTHRU_END_INTR_ENABLE 7
`define BIT_PASSTHRU_IN_PROGRESS 6
`define BIT_PASSTHRU_ENABLE 5
`define BIT_USB_IRQ_MGMT_INTR_ENABLE 4
`define BIT_CMD_PORT_WRITE_TRAP_ENABLE 3
`define BIT_CMD_PORT_READ_TRAP_ENABLE 2
`define BIT_DATA_PORT_WRITE_TRAP_ENABLE 1
`define BIT_DATA_PORT_READ_TRAP_ENABLE 0
// Write-one-to-clear status bits and plain read/write bits
`define W1C_MASK 16'h8F00
`define RW_MASK 16'h20BF
// Keyboard controller ports and command values
`define KBD_DATA_PORT 16'h0060
`define KBD_CMD_PORT 16'h0064
`define GATE_START_CMD 8'hD1
`define GATE_END_CMD 8'hFF
`endif

// ==== logic/port_access_decode.v ====
`timescale 1ns/1ps
// Classifies one host I/O cycle on the keyboard ports into four strobes
module port_access_decode (
   input wire IO_VALID,
   input wire IO_WRITE,
   input wire [15:0] IO_ADDR,
   output wire DATA_RD,
   output wire DATA_WR,
   output wire CMD_RD,
   output wire CMD_WR
);
`include "legacy_kbd_regs.vh"
   wire is_data;
   wire is_cmd;
   assign is_data = IO_VALID && (IO_ADDR == `KBD_DATA_PORT);
   assign is_cmd = IO_VALID && (IO_ADDR == `KBD_CMD_PORT);
   assign DATA_RD = is_data && !IO_WRITE;
   assign DATA_WR = is_data && IO_WRITE;
   assign CMD_RD = is_cmd && !IO_WRITE;
   assign CMD_WR = is_cmd && IO_WRITE;
endmodule // port_access_decode

// ==== logic/legacy_kbd_port_trap_smi.v ====
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Sequence end sets bit 15; write-one clears
// [RULE2] Bit 13 gates USB interrupt onto line
// [RULE3] Bit 12 mirrors USB request, read only
// [RULE4] Command port write sets bit 11
// [RULE5] Command port read sets bit 10
// [RULE6] Data port write sets bit 9
// [RULE7] Data port read sets bit 8
// [RULE8] Bit 7 enables interrupt at sequence end
// [RULE9] Bit 6 shows sequence in progress
// [RULE10] Bit 5 enables sequencer; clearing aborts it
// [RULE11] Sequence starts with D1h command writes
// [RULE12] Then one data write, command reads
// [RULE13] FFh command write closes sequence normally
// [RULE14] Deviation exits; access handled as normal
// [RULE15] No management interrupt during a sequence
// [RULE16] Sequence accesses set no trap status
// [RULE17] Bit 4: USB request raises interrupt
// [RULE18] Bit 3: command write trap and interrupt
// [RULE19] Bit 2: command read trap and interrupt
// [RULE20] Bit 1: data write trap and interrupt
// [RULE21] Bit 0: data read trap and interrupt
// [RULE22] Register resets to 2000h
// [RULE23] Routed USB interrupt ORed with shared line
// [RULE24] Interrupt while status meets its enable
module legacy_kbd_port_trap_smi (
   input wire SYS_CLK,
   input wire RST,
   input wire CFG_WRITE,
   input wire CFG_READ,
   input wire [7:0] CFG_OFFSET,
   input wire [1:0] CFG_BYTE_EN,
   input wire [15:0] CFG_WDATA,
   output reg [15:0] CFG_RDATA,
   input wire IO_VALID,
   input wire IO_WRITE,
   input wire [15:0] IO_ADDR,
   input wire [7:0] IO_WDATA,
   input wire USB_IRQ,
   input wire SHARED_PCI_IRQ_LINE,
   output wire IRQ_TO_CONTROLLER,
   output wire IO_TRAP,
   output reg SYS_MGMT_INTR
);
`include "legacy_kbd_regs.vh"

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_START = 4'b0010;
   localparam [3:0] ST_DATA = 4'b0100;
   localparam [3:0] ST_POLL = 4'b1000;

   reg [15:0] ctrl;
   reg [3:0] state;
   reg [3:0] next_state;
   reg seq_part;
   reg seq_done;
   reg [15:0] next_ctrl;
   reg [15:0] cfg_clr;
   reg [15:0] cfg_wen;
   wire data_rd;
   wire data_wr;
   wire cmd_rd;
   wire cmd_wr;
   wire running;
   wire cfg_hit;
   wire [15:0] status_view;
   wire mgmt_cause;

   port_access_decode u_decode (
      .IO_VALID(IO_VALID),
      .IO_WRITE(IO_WRITE),
      .IO_ADDR(IO_ADDR),
      .DATA_RD(data_rd),
      .DATA_WR(data_wr),
      .CMD_RD(cmd_rd),
      .CMD_WR(cmd_wr)
   );

   assign cfg_hit = (CFG_OFFSET == `LEGACY_KBD_SUPPORT_CTRL_OFFSET);
   assign running = !state[0];

   ////////////////////////////////////////////////////////////////////////////
   // Pass-through sequencer
   always @* begin
      next_state = state;
      seq_part = 1'b0;
      seq_done = 1'b0;
      // Abort on the clearing write itself, not one cycle later
      if (!ctrl[`BIT_PASSTHRU_ENABLE] ||
         (cfg_wen[`BIT_PASSTHRU_ENABLE] && !CFG_WDATA[`BIT_PASSTHRU_ENABLE])) begin
         next_state = ST_IDLE; // [RULE10]
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_wr && IO_WDATA == `GATE_START_CMD) begin
                  next_state = ST_START; // [RULE11]
                  seq_part = 1'b1;
               end
            end
            ST_START: begin
               if (cmd_wr && IO_WDATA == `GATE_START_CMD) begin
                  seq_part = 1'b1; // [RULE11]
               end else if (data_wr) begin
                  next_state = ST_DATA; // [RULE12]
                  seq_part = 1'b1;
               end else if (data_rd || cmd_rd || cmd_wr) begin
                  next_state = ST_IDLE; // [RULE14]
               end
            end
            ST_DATA, ST_POLL: begin
               if (cmd_rd) begin
                  next_state = ST_POLL; // [RULE12]
                  seq_part = 1'b1;
               end else if (cmd_wr && IO_WDATA == `GATE_END_CMD) begin
                  next_state = ST_IDLE; // [RULE13]
                  seq_part = 1'b1;
                  seq_done = 1'b1;
               end else if (data_rd || data_wr || cmd_wr) begin
                  next_state = ST_IDLE; // [RULE14]
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register update; hardware set beats software clear in the same cycle
   always @* begin
      cfg_wen = 16'h0000;
      if (CFG_WRITE && cfg_hit) begin
         cfg_wen = {{8{CFG_BYTE_EN[1]}}, {8{CFG_BYTE_EN[0]}}};
      end
      cfg_clr = cfg_wen & CFG_WDATA & `W1C_MASK;
      next_ctrl = (ctrl & ~(cfg_wen & `RW_MASK)) | (CFG_WDATA & cfg_wen & `RW_MASK);
      next_ctrl = next_ctrl & ~cfg_clr; // [RULE1]
      if (seq_done) begin
         next_ctrl[`BIT_PASSTHRU_ENDED_STATUS] = 1'b1; // [RULE1]
      end
      // Accesses absorbed by the sequence leave trap status alone
      if (!seq_part) begin
         if (cmd_wr) next_ctrl[`BIT_CMD_PORT_WRITE_STATUS] = 1'b1; // [RULE4] [RULE16]
         if (cmd_rd) next_ctrl[`BIT_CMD_PORT_READ_STATUS] = 1'b1; // [RULE5] [RULE16]
         if (data_wr) next_ctrl[`BIT_DATA_PORT_WRITE_STATUS] = 1'b1; // [RULE6] [RULE16]
         if (data_rd) next_ctrl[`BIT_DATA_PORT_READ_STATUS] = 1'b1; // [RULE7] [RULE16]
      end
   end

   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ctrl <= `LEGACY_KBD_SUPPORT_CTRL_RESET; // [RULE22]
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // Bits 12 and 6 are live views, never stored
   assign status_view = {ctrl[15:13], USB_IRQ, ctrl[11:7], running, ctrl[5:0]}; // [RULE3] [RULE9]

   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         CFG_RDATA <= 16'h0000;
      end else if (CFG_READ && cfg_hit) begin
         CFG_RDATA <= status_view & 16'hBFFF;
      end else if (CFG_READ) begin
         CFG_RDATA <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt routing and management interrupt
   assign IRQ_TO_CONTROLLER = SHARED_PCI_IRQ_LINE |
      (USB_IRQ & ctrl[`BIT_USB_IRQ_ROUTE_ENABLE]); // [RULE2] [RULE23]

   // Trap pulses only for accesses handled normally
   assign IO_TRAP = !seq_part &&
      ((cmd_wr && ctrl[`BIT_CMD_PORT_WRITE_TRAP_ENABLE]) || // [RULE18]
       (cmd_rd && ctrl[`BIT_CMD_PORT_READ_TRAP_ENABLE]) || // [RULE19]
       (data_wr && ctrl[`BIT_DATA_PORT_WRITE_TRAP_ENABLE]) || // [RULE20]
       (data_rd && ctrl[`BIT_DATA_PORT_READ_TRAP_ENABLE])); // [RULE21]

   // Level from sticky status and live USB_IRQ, so clearing status drops its interrupt
   assign mgmt_cause =
      (ctrl[`BIT_PASSTHRU_ENDED_STATUS] & ctrl[`BIT_PASSTHRU_END_INTR_ENABLE]) | // [RULE8]
      (USB_IRQ & ctrl[`BIT_USB_IRQ_MGMT_INTR_ENABLE]) | // [RULE17]
      (ctrl[`BIT_CMD_PORT_WRITE_STATUS] & ctrl[`BIT_CMD_PORT_WRITE_TRAP_ENABLE]) | // [RULE18]
      (ctrl[`BIT_CMD_PORT_READ_STATUS] & ctrl[`BIT_CMD_PORT_READ_TRAP_ENABLE]) | // [RULE19]
      (ctrl[`BIT_DATA_PORT_WRITE_STATUS] & ctrl[`BIT_DATA_PORT_WRITE_TRAP_ENABLE]) | // [RULE20]
      (ctrl[`BIT_DATA_PORT_READ_STATUS] & ctrl[`BIT_DATA_PORT_READ_TRAP_ENABLE]); // [RULE21]

   always @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         SYS_MGMT_INTR <= 1'b0;
      end else begin
         SYS_MGMT_INTR <= mgmt_cause && !running; // [RULE15] [RULE24]
      end
   end
endmodule // legacy_kbd_port_trap_smi

// ==== verif/kbd_host_model.sv ====
`timescale 1ns/1ps
module kbd_host_model (
   input wire clk,
   output reg [27:0] cfg_bus,
   output reg [25:0] io_bus
);
   initial {cfg_bus, io_bus} = 54'h0;
   ////////////////////////
   // One-cycle strobes; data inverted after release so stale values are never trusted
   task cfg(input rd, input [7:0] o, input [1:0] b, input [15:0] d);
      begin
         @(negedge clk);
         cfg_bus = {rd, !rd, o, b, d};
         @(negedge clk);
         cfg_bus = {2'h0, o, b, ~d};
      end
   endtask
   task io(input w, input [15:0] a, input [7:0] d);
      begin
         @(negedge clk);
         io_bus = {1'b1, w, a, d};
         @(negedge clk);
         io_bus = {1'b0, w, a, ~d};
      end
   endtask
endmodule // kbd_host_model

// ==== verif/legacy_kbd_port_trap_smi_asserts.sv ====
`timescale 1ns/1ps
module kbd_trap_checker (
   input wire SYS_CLK,
   input wire RST,
   input wire CFG_WRITE,
   input wire CFG_READ,
   input wire [15:0] CFG_RDATA,
   input wire IO_VALID,
   input wire [15:0] IO_ADDR,
   input wire USB_IRQ,
   input wire SHARED_PCI_IRQ_LINE,
   input wire IRQ_TO_CONTROLLER,
   input wire IO_TRAP,
   input wire SYS_MGMT_INTR
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_rt; !USB_IRQ |-> IRQ_TO_CONTROLLER == SHARED_PCI_IRQ_LINE; endproperty
   a_rt: assert property (p_rt) else $error("route");
   property p_or; SHARED_PCI_IRQ_LINE |-> IRQ_TO_CONTROLLER; endproperty
   a_or: assert property (p_or) else $error("or");
   property p_usb; CFG_READ ##1 CFG_RDATA[12] |-> $past(USB_IRQ); endproperty
   a_usb: assert property (p_usb) else $error("usb bit");
   property p_hold; !CFG_READ |=> $stable(CFG_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("rdata");
   property p_site; IO_TRAP |-> IO_VALID && (IO_ADDR == 16'h0060 || IO_ADDR == 16'h0064); endproperty
   a_site: assert property (p_site) else $error("trap site");
   property p_trap; IO_TRAP ##1 !(CFG_WRITE || IO_VALID) |=> SYS_MGMT_INTR; endproperty
   a_trap: assert property (p_trap) else $error("trap smi");
   // Access and config causes lag two edges: status or mask first, then the registered output; USB_IRQ lags one
   property p_rise; $rose(SYS_MGMT_INTR) |->
      $past(IO_VALID, 2) || $past(CFG_WRITE, 2) || $past(USB_IRQ); endproperty
   a_rise: assert property (p_rise) else $error("rise");
   property p_fall; $fell(SYS_MGMT_INTR) |->
      $past(IO_VALID, 2) || $past(CFG_WRITE, 2) || !$past(USB_IRQ); endproperty
   a_fall: assert property (p_fall) else $error("fall");
endmodule // kbd_trap_checker
bind legacy_kbd_port_trap_smi kbd_trap_checker i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
   .CFG_WRITE(CFG_WRITE), .CFG_READ(CFG_READ), .CFG_RDATA(CFG_RDATA), .IO_VALID(IO_VALID),
   .IO_ADDR(IO_ADDR), .USB_IRQ(USB_IRQ), .SHARED_PCI_IRQ_LINE(SHARED_PCI_IRQ_LINE),
   .IRQ_TO_CONTROLLER(IRQ_TO_CONTROLLER), .IO_TRAP(IO_TRAP), .SYS_MGMT_INTR(SYS_MGMT_INTR));

// ==== verif/legacy_kbd_port_trap_smi_test.sv ====
`timescale 1ns/1ps
module legacy_kbd_port_trap_smi_test;
   reg clk, rst, usb, shd;
   reg trap_seen;
   reg [31:0] r;
   wire irq, trap, smi;
   wire [27:0] cb;
   wire [25:0] ib;
   wire [15:0] rdat;
   integer m, st, n, error_cnt, check_count, k;
   kbd_host_model i_host (.clk(clk), .cfg_bus(cb), .io_bus(ib));
   legacy_kbd_port_trap_smi i_dut (.SYS_CLK(clk), .RST(rst), .CFG_READ(cb[27]), .CFG_WRITE(cb[26]),
      .CFG_OFFSET(cb[25:18]), .CFG_BYTE_EN(cb[17:16]), .CFG_WDATA(cb[15:0]), .CFG_RDATA(rdat),
      .IO_VALID(ib[25]), .IO_WRITE(ib[24]), .IO_ADDR(ib[23:8]), .IO_WDATA(ib[7:0]), .USB_IRQ(usb),
      .SHARED_PCI_IRQ_LINE(shd), .IRQ_TO_CONTROLLER(irq), .IO_TRAP(trap), .SYS_MGMT_INTR(smi));
   ////////////////////////
   // Trap pulse is combinational; hold what the access edge saw
   always @(posedge clk) trap_seen <= trap;
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task chk(input [39:0] nm, input [15:0] e, input [15:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Model state: 0 idle, 1 start seen, 2 data written, 3 polling
   task io(input integer p, input integer w, input [7:0] d);
      begin
         i_host.io(w[0], p ? 16'h0064 : 16'h0060, d);
         n = 5;
         if (m[5] && p && w && d == 8'hD1 && st < 2) n = 1;
         else if (m[5] && !p && w && st == 1) n = 2;
         else if (m[5] && p && !w && st > 1) n = 3;
         else if (m[5] && p && w && d == 8'hFF && st > 1) n = 4;
         chk("trap", n == 5 && m[2 * p + w], trap_seen);
         if (n == 5) m[8 + 2 * p + w] = 1;
         if (n == 4) m[15] = 1;
         st = (n > 3) ? 0 : n;
      end
   endtask
   task wr(input [7:0] o, input [1:0] b, input [15:0] d);
      reg [15:0] bm;
      begin
         i_host.cfg(1'b0, o, b, d);
         bm = {{8{b[1]}}, {8{b[0]}}} & {16{o == 8'hC0}};
         m = m & ~(d & bm & 16'h8F00) & ~(bm & 16'h20BF) | d & bm & 16'h20BF;
         if (!m[5]) st = 0;
      end
   endtask
   task rd(input [7:0] o);
      begin
         i_host.cfg(1'b1, o, 2'h3, 16'h0000);
         chk("rdata", (o == 8'hC0) ? m | usb << 12 | (st != 0) << 6 : 0, rdat);
         chk("smi", st == 0 && (m[15] && m[7] || |(m[11:8] & m[3:0]) || usb && m[4]), smi);
         chk("irq", shd | usb & m[13], irq);
      end
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, usb, shd} = 3'h4;
      {m, st, error_cnt, check_count} = {32'h0000_2000, 96'h0};
      r = 32'h0000_F62B;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 0;
      rd(8'hC0);
      rd(8'hC2);
      wr(8'hC0, 2'h3, 16'h20AF);
      io(1, 1, 8'hD1);
      io(1, 1, 8'hD1);
      rd(8'hC0);
      io(0, 1, 8'h5A);
      io(1, 0, 8'h00);
      io(1, 1, 8'hFF);
      rd(8'hC0);
      io(1, 1, 8'hD1);
      io(0, 0, 8'h00);
      rd(8'hC0);
      io(1, 1, 8'hD1);
      wr(8'hC0, 2'h1, 16'h0000);
      rd(8'hC0);
      for (k = 0; k < 400; k = k + 1) begin
         r = xs(r);
         {usb, shd} = r[1:0];
         if (r[3:2] != 0)
            io(r[4], r[5], r[6] ? 8'hD1 : r[7] ? 8'hFF : r[15:8]);
         else
            wr(r[8] ? 8'hC0 : 8'hC4, r[10:9], r[31:16]);
         rd(8'hC0);
      end
      close_out;
   end
endmodule // legacy_kbd_port_trap_smi_test
